// >>> hdl/mpn_maint_panel.sv
`timescale 1ns/1ps
// Function
// - memory op address comes from scratch word 31
// - whole word, low two address bits ignored
// - read switch plus start loads memory word
// - write switch plus start stores display register
// - address plus four unless inhibit switch set
// - nine-position selector picks one register
// - 32 lamps driven from adder output
// - halted adder passes display register unchanged
// - selected register onto input bus, strobe loads
// - select press arms, 170 ms then pulse
// - pulse sets load flag; flags clear each other
// - memory data register through bus separator
// - memory data valid only after stop conditions
// - only marked bits written back
// - set register copies display, then redisplays
module mpn_maint_panel
#(
	parameter int unsigned DEBOUNCE = mpn_pkg::DEBOUNCE_CYCLES
)
(
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// register bus
	input  wire logic [3:0]          busAddr,
	input  wire logic [31:0]         busWdata,
	input  wire logic                busWr,
	input  wire logic                busRd,
	output logic [31:0]              busRdata,
	// operator panel
	input  wire mpn_pkg::mpn_sw_t    panelSw,
	input  wire logic [31:0]         dataSw,
	output logic [31:0]              lamps,
	// processor side
	input  wire mpn_pkg::mpn_cpu_t   cpu,
	input  wire logic [31:0]         adderResult,
	input  wire logic [9*32-1:0]     regSrc,
	output logic [31:0]              inputBus,
	output logic [8:0]               regWrEn,
	output logic [31:0]              regWrData,
	output logic                     displayLoadStrobe,
	// scratch pad
	output logic [4:0]               spAddr,
	output logic                     spRd,
	output logic                     spWr,
	output logic [31:0]              spWdata,
	input  wire logic [31:0]         spRdata,
	// main memory
	output logic                     memReq,
	output logic                     memWe,
	output logic [31:0]              memAddr,
	output logic [31:0]              memWdata,
	input  wire logic                memAck,
	input  wire logic [31:0]         memRdata
);
	import mpn_pkg::*;

	// refuse a debounce count the 24-bit counter cannot hold
	if (DEBOUNCE < 1 || DEBOUNCE > 32'h00ff_ffff)
	begin : gen_bad_debounce
		$error("debounce count out of range");
	end

	localparam logic [23:0] DEB_LAST   = 24'(DEBOUNCE - 1);
	localparam logic [3:0]  PULSE_LAST = 4'(PULSE_CYCLES - 1);

	mpn_sw_t     swMeta_reg;      // first synchroniser stage
	mpn_sw_t     sw_reg;          // synchronised switches
	mpn_sw_t     swPrev_reg;      // for edge detection
	logic [31:0] dataMeta_reg;    // first stage, data switches
	logic [31:0] data_reg;        // synchronised data switches
	logic [31:0] dataPrev_reg;    // for edge detection
	logic [31:0] display_reg;     // display data register
	logic [31:0] addrHold_reg;    // address fetched from scratch pad
	logic        isWrite_reg;     // current manual op direction
	logic        armed_reg;       // seq_armed_flag
	logic        loadFlag_reg;    // seq_load_flag
	logic [23:0] debCnt_reg;      // debounce one-shot
	logic        debRun_reg;      // debounce timing active
	logic [3:0]  pulseCnt_reg;    // pulse width counter
	logic        debouncedPulse_n_reg; // active-low debounced pulse
	logic        setPending_reg;  // set register held down
	logic [8:0]  selLatch_reg;    // position captured at arm time
	mpn_state_t  state_reg;
	mpn_state_t  state_next;

	logic        startEdge;       // start button pressed
	logic        anySelPress;     // any_select_sw_pressed
	logic        setPress;        // set register pressed
	logic        setRelease;      // set register released
	logic        seqIdle;         // both sequencer flags clear and debounce timing not active
	logic        memDataValid;    // memory data register holds memory contents
	logic [31:0] busNext;         // input bus before register
	logic [31:0] selMask;         // modifiable bits of selected register
	logic [31:0] dataPress;       // data switch rising edges

	// two-stage synchronisers for all panel inputs
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			swMeta_reg   <= '0;
			sw_reg       <= '0;
			swPrev_reg   <= '0;
			dataMeta_reg <= 32'h0000_0000;
			data_reg     <= 32'h0000_0000;
			dataPrev_reg <= 32'h0000_0000;
		end
		else
		begin
			swMeta_reg   <= panelSw;
			sw_reg       <= swMeta_reg;
			swPrev_reg   <= sw_reg;
			dataMeta_reg <= dataSw;
			data_reg     <= dataMeta_reg;
			dataPrev_reg <= data_reg;
		end
	end

	// edges and decode
	assign startEdge   = sw_reg.start & ~swPrev_reg.start;
	assign anySelPress = |(sw_reg.sel & ~swPrev_reg.sel);
	assign setPress    = sw_reg.setReg & ~swPrev_reg.setReg;
	assign setRelease  = ~sw_reg.setReg & swPrev_reg.setReg;
	assign dataPress   = data_reg & ~dataPrev_reg;
	assign seqIdle     = ~armed_reg & ~loadFlag_reg & ~debRun_reg;
	assign memDataValid = cpu.machErrStop | (cpu.memAddrLevel & cpu.singleStep);

	// selected register onto the input bus
	always_comb
	begin
		busNext = 32'h0000_0000;
		selMask = 32'h0000_0000;
		for (int i = 0; i < SEL_COUNT; i++)
		begin
			if (selLatch_reg[i])
			begin
				busNext = regSrc[i*32 +: 32];
				selMask = MODIFY_MASKS[i*32 +: 32];
			end
		end
		if (selLatch_reg[SEL_MEMDATA] && !memDataValid)
			busNext = 32'h0000_0000;
	end

	// registered input bus
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			inputBus <= 32'h0000_0000;
		else
			inputBus <= busNext;
	end

	// selector position captured when a sequence starts
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			selLatch_reg <= 9'h000;
		else if (anySelPress && seqIdle)
			selLatch_reg <= sw_reg.sel;
	end

	// armed flag
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			armed_reg <= 1'b0;
		else if ((anySelPress || setRelease) && seqIdle)
			armed_reg <= 1'b1;
		else if (loadFlag_reg)
			armed_reg <= 1'b0;
	end

	// debounce delay then one-microsecond low pulse
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			debRun_reg           <= 1'b0;
			debCnt_reg           <= 24'h00_0000;
			pulseCnt_reg         <= 4'h0;
			debouncedPulse_n_reg <= 1'b1;
		end
		else if (!debRun_reg)
		begin
			// trigger on arming
			if ((anySelPress || setRelease) && seqIdle)
			begin
				debRun_reg <= 1'b1;
				debCnt_reg <= 24'h00_0000;
			end
		end
		else if (debouncedPulse_n_reg)
		begin
			// settle time
			if (debCnt_reg == DEB_LAST)
			begin
				debouncedPulse_n_reg <= 1'b0;
				pulseCnt_reg         <= 4'h0;
			end
			else
				debCnt_reg <= debCnt_reg + 24'h00_0001;
		end
		else if (pulseCnt_reg == PULSE_LAST)
		begin
			debouncedPulse_n_reg <= 1'b1;
			debRun_reg           <= 1'b0;
		end
		else
			pulseCnt_reg <= pulseCnt_reg + 4'h1;
	end

	// load flag
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			loadFlag_reg <= 1'b0;
		else if (!armed_reg)
			loadFlag_reg <= 1'b0;
		else if (!debouncedPulse_n_reg)
			loadFlag_reg <= 1'b1;
	end

	// display load strobe, one cycle at load flag rise
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			displayLoadStrobe <= 1'b0;
		else
			displayLoadStrobe <= ~armed_reg ? 1'b0 : (~debouncedPulse_n_reg & ~loadFlag_reg);
	end

	// set register write-back
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			setPending_reg <= 1'b0;
			regWrEn        <= 9'h000;
			regWrData      <= 32'h0000_0000;
		end
		else
		begin
			regWrEn <= 9'h000;
			if (setPress && seqIdle && !cpu.running)
			begin
				setPending_reg <= 1'b1;
				regWrEn        <= selLatch_reg;
				regWrData      <= display_reg & selMask;
			end
			else if (setRelease)
				setPending_reg <= 1'b0;
		end
	end

	// manual memory sequence, next state
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
				if (startEdge && !cpu.running && (sw_reg.memRead ^ sw_reg.memWrite))
					state_next = ST_SPRD;
			ST_SPRD:
				state_next = ST_SPCAP;
			ST_SPCAP:
				state_next = ST_MEM;
			ST_MEM:
				if (memAck)
					state_next = ST_INC;
			ST_INC:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// manual memory sequence, state
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// direction captured at start
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			isWrite_reg <= 1'b0;
		else if (state_reg == ST_IDLE)
			isWrite_reg <= sw_reg.memWrite;
	end

	// scratch-pad port
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			spAddr       <= 5'h00;
			spRd         <= 1'b0;
			spWr         <= 1'b0;
			spWdata      <= 32'h0000_0000;
			addrHold_reg <= 32'h0000_0000;
		end
		else
		begin
			spRd <= 1'b0;
			spWr <= 1'b0;
			if (state_reg == ST_IDLE && state_next == ST_SPRD)
			begin
				spAddr <= SP_ADDR_WORD;
				spRd   <= 1'b1;
			end
			if (state_reg == ST_SPCAP)
				addrHold_reg <= spRdata;
			if (state_reg == ST_INC && !sw_reg.incInhibit)
			begin
				spAddr  <= SP_ADDR_WORD;
				spWr    <= 1'b1;
				spWdata <= addrHold_reg + ADDR_STEP;
			end
		end
	end

	// main memory port
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			memReq   <= 1'b0;
			memWe    <= 1'b0;
			memAddr  <= 32'h0000_0000;
			memWdata <= 32'h0000_0000;
		end
		else if (state_reg == ST_SPCAP)
		begin
			memReq   <= 1'b1;
			memWe    <= isWrite_reg;
			memAddr  <= spRdata & WORD_MASK;
			memWdata <= display_reg;
		end
		else if (state_reg == ST_MEM && memAck)
		begin
			memReq <= 1'b0;
			memWe  <= 1'b0;
		end
	end

	// display data register
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			display_reg <= DISPLAY_RESET;
		else if (state_reg == ST_MEM && memAck && !isWrite_reg)
			display_reg <= memRdata;
		else if (displayLoadStrobe)
			display_reg <= inputBus;
		else if (busWr && busAddr == REG_DISPLAY)
			display_reg <= busWdata;
		else if (|dataPress)
			display_reg <= display_reg | dataPress;
	end

	// lamps from the adder output while running, else the display register
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			lamps <= 32'h0000_0000;
		else
			lamps <= cpu.running ? adderResult : display_reg;
	end

	// register bus read port, data one cycle after strobe
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			busRdata <= 32'h0000_0000;
		else if (busRd)
		begin
			unique case (busAddr)
				REG_DISPLAY:
					busRdata <= display_reg;
				REG_STATUS:
					busRdata <= {15'h0000, state_reg, setPending_reg, memDataValid, debRun_reg,
						loadFlag_reg, armed_reg, selLatch_reg};
				REG_ADDR:
					busRdata <= addrHold_reg;
				default:
					busRdata <= 32'h0000_0000;
			endcase
		end
		else
			busRdata <= 32'h0000_0000;
	end

endmodule : mpn_maint_panel

// >>> hdl/mpn_pkg.sv
package mpn_pkg;

	// clock rate and one-shot timing
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned DEBOUNCE_MS     = 170;
	localparam int unsigned PULSE_US        = 1;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned PULSE_CYCLES    = PULSE_US * (CLK_HZ / 1_000_000);

	// manual memory access
	localparam logic [4:0]  SP_ADDR_WORD  = 5'h1f;        // scratch-pad word holding the address
	localparam logic [31:0] ADDR_STEP     = 32'h0000_0004; // one word
	localparam logic [31:0] WORD_MASK     = 32'hffff_fffc; // byte bits dropped

	// register bus map
	localparam logic [3:0]  REG_DISPLAY   = 4'h0; // display data register, read/write
	localparam logic [3:0]  REG_STATUS    = 4'h4; // panel state, read only
	localparam logic [3:0]  REG_ADDR      = 4'h8; // last manual address, read only
	localparam logic [31:0] DISPLAY_RESET = 32'h0000_0000;

	// selector positions
	localparam int unsigned SEL_COUNT = 9;
	localparam int unsigned SEL_SPADDR   = 0;
	localparam int unsigned SEL_MEMADDR  = 1;
	localparam int unsigned SEL_MEMDATA  = 2;
	localparam int unsigned SEL_UTILITY  = 3;
	localparam int unsigned SEL_INTERMED = 4;
	localparam int unsigned SEL_OPCODE   = 5;
	localparam int unsigned SEL_N     = 6;
	localparam int unsigned SEL_STAT  = 7;
	localparam int unsigned SEL_SPARE = 8;

	// bits that may be written back, per selector position
	localparam logic [SEL_COUNT*32-1:0] MODIFY_MASKS = {
		32'h0000_0000, // spare
		32'h0000_0000, // status
		32'h7f70_0000, // n counter
		32'h37c0_0f0f, // opcode
		32'hffff_ffff, // intermediate
		32'hffff_ffff, // utility
		32'hffff_ffff, // memory data
		32'h0000_0000, // memory address
		32'h0000_0000  // scratch-pad address
	};

	// operator switches, all asynchronous
	typedef struct packed {
		logic       memRead;
		logic       memWrite;
		logic       incInhibit;
		logic       start;
		logic       setReg;
		logic [8:0] sel;
	} mpn_sw_t;

	// processor condition levels, same clock
	typedef struct packed {
		logic running;
		logic machErrStop;
		logic memAddrLevel;
		logic singleStep;
	} mpn_cpu_t;

	// manual memory sequence
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SPRD  = 3'b001,
		ST_SPCAP = 3'b010,
		ST_MEM   = 3'b011,
		ST_INC   = 3'b100
	} mpn_state_t;

endpackage : mpn_pkg

// >>> tb/mpn_maint_panel_checker.sv
`timescale 1ns/1ps
// port-level checks for the maintenance panel
module mpn_maint_panel_checker
#(
	parameter int unsigned DEBOUNCE = mpn_pkg::DEBOUNCE_CYCLES
)
(
	input wire logic              clk_sys,
	input wire logic              rstn,
	input wire logic [31:0]       lamps,
	input wire mpn_pkg::mpn_cpu_t cpu,
	input wire logic [31:0]       adderResult,
	input wire logic [8:0]        regWrEn,
	input wire logic [31:0]       regWrData,
	input wire logic              displayLoadStrobe,
	input wire logic [4:0]        spAddr,
	input wire logic              spRd,
	input wire logic              spWr,
	input wire logic [31:0]       spWdata,
	input wire logic [31:0]       spRdata,
	input wire logic              memReq,
	input wire logic              memWe,
	input wire logic [31:0]       memAddr,
	input wire logic              memAck
);
	import mpn_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic        spRdPrev; // scratch read last cycle
	logic [31:0] spCap;    // scratch word as returned
	logic [31:0] wrMask;   // mask of the written position
	int unsigned gapCnt;   // cycles since last strobe
	// capture the scratch word one cycle after its read
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			spRdPrev <= 1'b0;
			spCap    <= 32'h0000_0000;
		end
		else
		begin
			spRdPrev <= spRd;
			if (spRdPrev)
				spCap <= spRdata;
		end
	end
	// count strobe spacing, saturating
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			gapCnt <= DEBOUNCE;
		else if (displayLoadStrobe)
			gapCnt <= 0;
		else if (gapCnt < DEBOUNCE)
			gapCnt <= gapCnt + 1;
	end
	// writable bits of the strobed position
	always_comb
	begin
		wrMask = 32'h0000_0000;
		for (int i = 0; i < SEL_COUNT; i++)
			if (regWrEn[i])
				wrMask = wrMask | MODIFY_MASKS[i*32 +: 32];
	end
	AST_SP_WORD: assert property (spRd || spWr |-> spAddr == SP_ADDR_WORD)
		else $error("scratch access off word 31");
	AST_SEQ: assert property (spRd |-> ##2 memReq)
		else $error("memory request late after scratch read");
	AST_MEM_ADDR: assert property (memReq |-> memAddr == (spCap & WORD_MASK))
		else $error("memory address not aligned scratch word");
	AST_MEM_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
		else $error("memory request changed before ack");
	AST_SP_INC: assert property (spWr |-> spWdata == spCap + ADDR_STEP)
		else $error("scratch address not stepped by four");
	AST_ONE_REG: assert property (regWrEn != 9'h000 |-> $onehot(regWrEn) ##1 regWrEn == 9'h000)
		else $error("register write not a one-hot pulse");
	AST_LAMP_ADDER: assert property ($past(cpu.running) |-> lamps == $past(adderResult))
		else $error("lamps not from adder");
	AST_STROBE_ONE: assert property (displayLoadStrobe |=> !displayLoadStrobe)
		else $error("load strobe longer than one cycle");
	AST_STROBE_GAP: assert property (displayLoadStrobe |-> gapCnt >= DEBOUNCE)
		else $error("load strobes closer than debounce");
	AST_WR_MASK: assert property (regWrEn != 9'h000 |-> (regWrData & ~wrMask) == 32'h0000_0000)
		else $error("write-back touches protected bits");
endmodule : mpn_maint_panel_checker

bind mpn_maint_panel mpn_maint_panel_checker #(.DEBOUNCE(DEBOUNCE)) mpn_maint_panel_checker_i (
	.clk_sys, .rstn, .lamps, .cpu, .adderResult, .regWrEn, .regWrData, .displayLoadStrobe,
	.spAddr, .spRd, .spWr, .spWdata, .spRdata, .memReq, .memWe, .memAddr, .memAck);

// >>> tb/mpn_mem_model.sv
`timescale 1ns/1ps
// far side: scratch word 31 and a small main memory
module mpn_mem_model
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [4:0]  spAddr,
	input  wire logic        spRd,
	input  wire logic        spWr,
	input  wire logic [31:0] spWdata,
	output logic      [31:0] spRdata,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	input  wire logic [3:0]  waitCycles,
	output logic             memAck,
	output logic      [31:0] memRdata
);
	logic [31:0] spWord;    // scratch word 31, preset by the bench
	logic [31:0] store [16]; // memory words by word index
	logic [3:0]  waitCnt;   // cycles the request has waited
	// one process: scratch answer, memory answer after a wait
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			memAck   <= 1'b0;
			waitCnt  <= 4'h0;
			memRdata <= 32'h5a5a_a5a5;
			spRdata  <= 32'ha5a5_5a5a;
		end
		else
		begin
			spRdata  <= (spRd && spAddr == 5'h1f) ? spWord : ~spRdata;
			memAck   <= 1'b0;
			memRdata <= ~memRdata; // junk outside the ack
			if (spWr && spAddr == 5'h1f)
				spWord <= spWdata;
			if (memReq && !memAck)
			begin
				if (waitCnt == waitCycles)
				begin
					memAck   <= 1'b1;
					waitCnt  <= 4'h0;
					memRdata <= store[memAddr[5:2]];
					if (memWe)
						store[memAddr[5:2]] <= memWdata;
				end
				else
					waitCnt <= waitCnt + 4'h1;
			end
		end
	end
endmodule : mpn_mem_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
// panel bench: bus, manual memory ops, select and set-register
module testbench;
	import mpn_pkg::*;
	localparam int unsigned DEB = 20; // shortened debounce
	logic              clk_sys, rstn, busWr, busRd, displayLoadStrobe, spRd, spWr;
	logic              memReq, memWe, memAck, anyWr;
	logic [3:0]        busAddr, waitCycles;
	logic [4:0]        spAddr;
	logic [8:0]        regWrEn;
	logic [31:0]       busWdata, busRdata, dataSw, lamps, adderResult, inputBus, regWrData;
	logic [31:0]       spWdata, spRdata, memAddr, memWdata, memRdata;
	logic [9*32-1:0]   regSrc;
	mpn_sw_t           panelSw;
	mpn_cpu_t          cpu;
	int                miscompares, checks;
	assign anyWr = |regWrEn;
	mpn_maint_panel #(.DEBOUNCE(DEB)) mpn_maint_panel_i (.clk_sys, .rstn, .busAddr, .busWdata, .busWr, .busRd,
		.busRdata, .panelSw, .dataSw, .lamps, .cpu, .adderResult, .regSrc, .inputBus, .regWrEn, .regWrData,
		.displayLoadStrobe, .spAddr, .spRd, .spWr, .spWdata, .spRdata, .memReq, .memWe, .memAddr, .memWdata,
		.memAck, .memRdata);
	mpn_mem_model mpn_mem_model_i (.clk_sys, .rstn, .spAddr, .spRd, .spWr, .spWdata, .spRdata, .memReq,
		.memWe, .memAddr, .memWdata, .waitCycles, .memAck, .memRdata);
	// clock
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// bounded wait for a flag
	task automatic waitHigh(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1)
		begin
			@(posedge clk_sys);
			#1;
			n++;
			if (n > lim)
			begin
				miscompares++;
				$display("CHECK FAILED at %0t: wait timed out", $time);
				end_sim();
			end
		end
	endtask : waitHigh
	task automatic busW(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		busAddr  <= a;
		busWdata <= d;
		busWr    <= 1'b1;
		@(posedge clk_sys);
		busWr <= 1'b0;
	endtask : busW
	// read, data stands the cycle after the strobe
	task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		busAddr <= a;
		busRd   <= 1'b1;
		@(posedge clk_sys);
		busRd <= 1'b0;
		#1;
		chk(busRdata, exp);
	endtask : rdChk
	// expected input-bus word of a position
	function automatic logic [31:0] expSel(input int p);
		if (p == SEL_MEMDATA && !(cpu.machErrStop || (cpu.memAddrLevel && cpu.singleStep)))
			return 32'h0000_0000;
		return regSrc[p*32 +: 32];
	endfunction : expSel
	// one manual read or write through scratch word 31
	task automatic memOp(input logic wr, input logic inh);
		logic [31:0] a;
		logic [31:0] d;
		a = $urandom;
		d = $urandom;
		mpn_mem_model_i.spWord = a;
		if (wr)
			busW(REG_DISPLAY, d);
		else
			mpn_mem_model_i.store[a[5:2]] = d;
		@(posedge clk_sys);
		panelSw.memRead    <= !wr;
		panelSw.memWrite   <= wr;
		panelSw.incInhibit <= inh;
		panelSw.start      <= 1'b1;
		waitHigh(memAck, 100);
		panelSw.start <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(mpn_mem_model_i.spWord, inh ? a : a + ADDR_STEP);
		if (wr)
			chk(mpn_mem_model_i.store[a[5:2]], d);
		else
			rdChk(REG_DISPLAY, d);
		rdChk(REG_ADDR, a);
		chk(lamps, d);
	endtask : memOp
	// select a register, optionally a second press mid-sequence
	task automatic selReg(input int p, input logic extra);
		repeat (12) @(posedge clk_sys); // let a running sequence finish
		for (int i = 0; i < 9; i++)
			regSrc[i*32 +: 32] <= $urandom;
		panelSw.sel <= 9'h001 << p;
		repeat (4) @(posedge clk_sys);
		if (extra)
			panelSw.sel <= panelSw.sel | 9'h100;
		repeat (4) @(posedge clk_sys);
		panelSw.sel <= 9'h000;
		waitHigh(displayLoadStrobe, 100);
		rdChk(REG_DISPLAY, expSel(p));
		chk(lamps, expSel(p));
	endtask : selReg
	// write back the display register
	task automatic setRegOp(input int p);
		logic [31:0] d;
		d = $urandom;
		selReg(p, 1'b0);
		busW(REG_DISPLAY, d);
		repeat (8) @(posedge clk_sys); // pulse of the display sequence must end first
		panelSw.setReg <= 1'b1;
		waitHigh(anyWr, 20);
		chk({23'h0, regWrEn}, 32'h1 << p);
		chk(regWrData, d & MODIFY_MASKS[p*32 +: 32]);
		// far-side register takes the modifiable bits only
		regSrc[p*32 +: 32] <= (regSrc[p*32 +: 32] & ~MODIFY_MASKS[p*32 +: 32]) | (d & MODIFY_MASKS[p*32 +: 32]);
		panelSw.setReg <= 1'b0;
		waitHigh(displayLoadStrobe, 100);
		rdChk(REG_DISPLAY, expSel(p));
	endtask : setRegOp
	// main sequence
	initial
	begin
		logic [31:0] r;
		logic [31:0] q;
		{rstn, busWr, busRd, busAddr, busWdata, dataSw, adderResult, regSrc, waitCycles} = '0;
		panelSw = '0;
		cpu = '0;
		miscompares = 0;
		checks = 0;
		void'($urandom(32'h7fbd7816));
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		r = $urandom;
		rdChk(REG_DISPLAY, DISPLAY_RESET);
		busW(REG_DISPLAY, r);
		busW(REG_STATUS, ~r); // read-only, ignored
		rdChk(REG_DISPLAY, r);
		rdChk(4'hc, 32'h0000_0000);
		for (int n = 0; n < 8; n++)
		begin
			waitCycles <= 4'($urandom_range(7));
			memOp(n[0], n == 3 || n == 6);
		end
		// running: start refused, lamps follow the adder
		cpu.running     <= 1'b1;
		adderResult     <= $urandom;
		panelSw.memRead  <= 1'b1;
		panelSw.memWrite <= 1'b0;
		panelSw.start    <= 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		chk({31'h0, memReq}, 32'h0);
		chk(lamps, adderResult);
		panelSw.start <= 1'b0;
		cpu.running   <= 1'b0;
		for (int k = 0; k < 11; k++)
		begin
			cpu.machErrStop  <= (k == 9);
			cpu.memAddrLevel <= (k == 10);
			cpu.singleStep   <= (k == 10);
			selReg(k >= 9 ? SEL_MEMDATA : k, k == SEL_INTERMED);
		end
		cpu.machErrStop  <= 1'b0;
		cpu.memAddrLevel <= 1'b0;
		cpu.singleStep   <= 1'b0;
		setRegOp(SEL_UTILITY);
		setRegOp(SEL_OPCODE);
		setRegOp(SEL_N);
		// data switches only set display bits
		q = $urandom;
		busW(REG_DISPLAY, r);
		dataSw <= q;
		repeat (5) @(posedge clk_sys);
		rdChk(REG_DISPLAY, r | q);
		chk(lamps, r | q);
		end_sim();
	end
endmodule : testbench
